// [logic/tms_pkg.sv]
// shared constants and types of the two-wire master
package tms_pkg;
  localparam int CMD_W = 10;
  localparam int FIFO_DEPTH = 32;
  localparam int FILT_LEN = 3;
  localparam int NUM_IN = 3;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [3:0] ACK_IDX = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic PIN_DRIVE_LEVEL = 1'b0;
  localparam logic LINE_IDLE = 1'b1;

  typedef struct packed {
    logic tx;
    logic rx;
    logic [7:0] data;
  } tms_cmd_t;

  typedef enum logic [2:0] {
    ST_FREE = 3'b000,
    ST_START = 3'b001,
    ST_HOLD = 3'b010,
    ST_BYTE = 3'b011,
    ST_RSREL = 3'b100,
    ST_RSHI = 3'b101,
    ST_STOP1 = 3'b110,
    ST_STOP2 = 3'b111
  } tms_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] shift;
    logic is_tx;
    logic rx_after;
    logic rx_hold;
    logic start_req;
    logic stop_req;
    logic ack;
    logic rx_ready;
    logic [7:0] rx_data;
    logic txact;
    logic rxact;
    logic scl_seen;
    logic sda_low;
    logic scl_low;
    logic tx_empty;
    logic bclk_prev;
  } tms_core_t;

  // previous bit clock starts at the synchroniser's idle high, so reset makes no false edge
  localparam tms_core_t CORE_RST = '{bclk_prev: 1'b1, default: '0};
endpackage

// [logic/tms_sync_filt.sv]
// input synchroniser with optional agreement filter
`timescale 1ns/1ps
`default_nettype none
module tms_sync_filt (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic filt_on,
  input wire logic pin,
  output logic q
);
  logic s1_r, s2_r, q_r, q_nxt;
  logic [tms_pkg::FILT_LEN-1:0] hist_r, hist_nxt;

  // with the filter on, a level changes only once all three recent samples agree
  always_comb begin
    hist_nxt = {hist_r[tms_pkg::FILT_LEN-2:0], s2_r};
    if (!filt_on)
      q_nxt = s2_r;
    else if (&hist_r)
      q_nxt = 1'b1;
    else if (~|hist_r)
      q_nxt = 1'b0;
    else
      q_nxt = q_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= tms_pkg::LINE_IDLE;
      s2_r <= tms_pkg::LINE_IDLE;
      hist_r <= '1;
      q_r <= tms_pkg::LINE_IDLE;
    end else if (en) begin
      s1_r <= pin;
      s2_r <= s1_r;
      hist_r <= hist_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

  unfiltered_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    (en && !filt_on) |=> q_r == $past(s2_r)) else $error("unfiltered input lags");
endmodule
`default_nettype wire

// [logic/tms_fifo.sv]
// command fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module tms_fifo #(
  parameter int W = 10,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt, push, load;
  logic [W-1:0] od_r, od_nxt;

  // depth must be a power of two, pointers wrap freely
  always_comb begin
    // the word waiting in the output register counts toward the depth
    in_ready = (cnt_r + (AW+1)'(ov_r)) != (AW+1)'(D);
    push = en && in_valid && in_ready;
    load = en && (cnt_r != '0) && (!ov_r || out_ready);
    wr_nxt = wr_r + AW'(push);
    rd_nxt = rd_r + AW'(load);
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
    od_nxt = load ? mem[rd_r] : od_r;
    if (load)
      ov_nxt = 1'b1;
    else if (en && out_ready)
      ov_nxt = 1'b0;
    else
      ov_nxt = ov_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  assign out_valid = ov_r;
  assign out_data = od_r;
endmodule
`default_nettype wire

// [logic/tms_master.sv]
// single-master two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module tms_master (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic MASTER_ENABLE,
  input wire logic NOISE_FILTER_ON,
  input wire logic BIT_CLOCK,
  input wire logic START_REQUEST_SET,
  input wire logic STOP_REQUEST_SET,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire tms_pkg::tms_cmd_t CMD,
  input wire logic ACK_SETTING,
  input wire logic RX_READ,
  output logic START_REQUEST,
  output logic STOP_REQUEST,
  output logic TRANSMIT_REQUEST,
  output logic RECEIVE_REQUEST,
  output logic ACK_BIT,
  output logic TX_ACTIVE_FLAG,
  output logic RX_ACTIVE_FLAG,
  output logic RX_BYTE_READY,
  output logic [7:0] SHIFT_DATA_BYTE,
  output logic TX_EMPTY_EVENT,
  output logic BUS_BUSY,
  input wire logic SERIAL_DATA_PIN_I,
  output logic SERIAL_DATA_PIN_O,
  output logic SERIAL_DATA_PIN_OE,
  input wire logic SERIAL_CLOCK_PIN_I,
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE
);
  tms_pkg::tms_state_t state_r, state_nxt;
  tms_pkg::tms_core_t c_r, c_nxt;
  tms_pkg::tms_cmd_t head;
  logic head_v, pop, rise_ev, fall_ev, sda_f, scl_f, bclk_s;
  logic [tms_pkg::NUM_IN-1:0] raw_in, filt_sel, cond_q;

  function automatic logic bit_pull(input logic is_tx, input logic v);
    return is_tx & ~v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin conditioning; the bit clock is only synchronised, never filtered

  assign raw_in = {BIT_CLOCK, SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I};
  assign filt_sel = {1'b0, NOISE_FILTER_ON, NOISE_FILTER_ON};

  genvar gi;
  generate
    for (gi = 0; gi < tms_pkg::NUM_IN; gi++) begin : g_in
      tms_sync_filt u_cond (
        .clk(CLOCK),
        .rst_n(RESETN),
        .en(CE),
        .filt_on(filt_sel[gi]),
        .pin(raw_in[gi]),
        .q(cond_q[gi])
      );
    end
  endgenerate

  assign sda_f = cond_q[0];
  assign scl_f = cond_q[1];
  assign bclk_s = cond_q[2];

  // timer edges pace everything, gated off while disabled
  assign rise_ev = CE && MASTER_ENABLE && bclk_s && !c_r.bclk_prev;
  assign fall_ev = CE && MASTER_ENABLE && !bclk_s && c_r.bclk_prev;

  ////////////////////////////////////////////////////////////////////////
  // byte commands; a full queue back-pressures software

  tms_fifo #(
    .W(tms_pkg::CMD_W),
    .D(tms_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst_n(RESETN),
    .en(CE),
    .in_valid(CMD_VALID),
    .in_ready(CMD_READY),
    .in_data(CMD),
    .out_valid(head_v),
    .out_ready(pop),
    .out_data(head)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus sequencer

  always_comb begin
    state_nxt = state_r;
    c_nxt = c_r;
    pop = 1'b0;
    c_nxt.tx_empty = 1'b0;
    c_nxt.bclk_prev = bclk_s;
    if (c_r.scl_low)
      c_nxt.scl_seen = 1'b0;
    else if (scl_f)
      c_nxt.scl_seen = 1'b1;
    if (RX_READ)
      c_nxt.rx_ready = 1'b0;
    if (!MASTER_ENABLE) begin
      // queued requests survive, line activity does not
      state_nxt = tms_pkg::ST_FREE;
      c_nxt.sda_low = 1'b0;
      c_nxt.scl_low = 1'b0;
      c_nxt.txact = 1'b0;
      c_nxt.rxact = 1'b0;
      c_nxt.rx_after = 1'b0;
      c_nxt.rx_hold = 1'b0;
    end else begin
      case (state_r)
        tms_pkg::ST_FREE: begin
          if (fall_ev && c_r.start_req) begin
            c_nxt.sda_low = 1'b1;
            state_nxt = tms_pkg::ST_START;
          end
        end
        tms_pkg::ST_START: begin
          if (fall_ev) begin
            c_nxt.scl_low = 1'b1;
            c_nxt.start_req = 1'b0;
            state_nxt = tms_pkg::ST_HOLD;
          end
        end
        tms_pkg::ST_HOLD: begin
          // clock stays low here, pausing the bus
          if (fall_ev) begin
            if (head_v) begin
              pop = 1'b1;
              c_nxt.cnt = tms_pkg::CNT_RST;
              state_nxt = tms_pkg::ST_BYTE;
              if (head.tx) begin
                c_nxt.shift = head.data;
                c_nxt.sda_low = bit_pull(1'b1, head.data[7]);
                c_nxt.is_tx = 1'b1;
                c_nxt.txact = 1'b1;
                c_nxt.tx_empty = 1'b1;
                c_nxt.rx_after = head.rx;
              end else begin
                c_nxt.is_tx = 1'b0;
                c_nxt.sda_low = 1'b0;
                c_nxt.rxact = 1'b1;
                c_nxt.rx_hold = 1'b1;
              end
            end else if (c_r.start_req) begin
              c_nxt.sda_low = 1'b0;
              state_nxt = tms_pkg::ST_RSREL;
            end else if (c_r.stop_req) begin
              c_nxt.sda_low = 1'b1;
              state_nxt = tms_pkg::ST_STOP1;
            end
          end
        end
        tms_pkg::ST_BYTE: begin
          // a low clock line after release stalls the bit
          if (fall_ev && c_r.scl_seen) begin
            c_nxt.cnt = c_r.cnt + 4'h1;
            c_nxt.scl_low = 1'b1;
            c_nxt.shift = {c_r.shift[6:0], sda_f};
            if (!c_r.is_tx && c_r.cnt == tms_pkg::CNT_RST)
              c_nxt.rx_hold = 1'b0;
            if (c_r.cnt == tms_pkg::LAST_DATA_IDX) begin
              c_nxt.sda_low = !c_r.is_tx && !ACK_SETTING;
              if (!c_r.is_tx) begin
                c_nxt.rx_data = {c_r.shift[6:0], sda_f};
                c_nxt.rx_ready = 1'b1;
                c_nxt.rxact = 1'b0;
              end
            end else if (c_r.cnt == tms_pkg::ACK_IDX) begin
              c_nxt.sda_low = 1'b0;
              if (c_r.is_tx) begin
                c_nxt.ack = sda_f;
                c_nxt.txact = 1'b0;
              end
              if (c_r.rx_after) begin
                c_nxt.is_tx = 1'b0;
                c_nxt.rxact = 1'b1;
                c_nxt.rx_hold = 1'b1;
                c_nxt.rx_after = 1'b0;
                c_nxt.cnt = tms_pkg::CNT_RST;
              end else begin
                state_nxt = tms_pkg::ST_HOLD;
              end
            end else begin
              c_nxt.sda_low = bit_pull(c_r.is_tx, c_r.shift[6]);
            end
          end else if (rise_ev) begin
            c_nxt.scl_low = 1'b0;
          end
        end
        tms_pkg::ST_RSREL: begin
          if (rise_ev) begin
            c_nxt.scl_low = 1'b0;
            state_nxt = tms_pkg::ST_RSHI;
          end
        end
        tms_pkg::ST_RSHI: begin
          if (fall_ev && c_r.scl_seen) begin
            c_nxt.sda_low = 1'b1;
            state_nxt = tms_pkg::ST_START;
          end
        end
        tms_pkg::ST_STOP1: begin
          if (rise_ev) begin
            c_nxt.scl_low = 1'b0;
            state_nxt = tms_pkg::ST_STOP2;
          end
        end
        tms_pkg::ST_STOP2: begin
          if (fall_ev && c_r.scl_seen) begin
            c_nxt.sda_low = 1'b0;
            c_nxt.stop_req = 1'b0;
            state_nxt = tms_pkg::ST_FREE;
          end
        end
        default: begin
          state_nxt = tms_pkg::ST_FREE;
        end
      endcase
    end
    // a request arriving with its own clear is kept
    if (START_REQUEST_SET)
      c_nxt.start_req = 1'b1;
    if (STOP_REQUEST_SET)
      c_nxt.stop_req = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= tms_pkg::ST_FREE;
      c_r <= tms_pkg::CORE_RST;
    end else if (CE) begin
      state_r <= state_nxt;
      c_r <= c_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; pins only ever pull low

  assign SERIAL_DATA_PIN_O = tms_pkg::PIN_DRIVE_LEVEL;
  assign SERIAL_CLOCK_PIN_O = tms_pkg::PIN_DRIVE_LEVEL;
  assign SERIAL_DATA_PIN_OE = c_r.sda_low;
  assign SERIAL_CLOCK_PIN_OE = c_r.scl_low;
  assign START_REQUEST = c_r.start_req;
  assign STOP_REQUEST = c_r.stop_req;
  assign TRANSMIT_REQUEST = head_v && head.tx;
  assign RECEIVE_REQUEST = c_r.rx_hold || c_r.rx_after || (head_v && head.rx);
  assign ACK_BIT = c_r.ack;
  assign TX_ACTIVE_FLAG = c_r.txact;
  assign RX_ACTIVE_FLAG = c_r.rxact;
  assign RX_BYTE_READY = c_r.rx_ready;
  assign SHIFT_DATA_BYTE = c_r.rx_data;
  assign TX_EMPTY_EVENT = c_r.tx_empty;
  assign BUS_BUSY = state_r != tms_pkg::ST_FREE;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  start_self_clear_a: assert property (
    (state_r == tms_pkg::ST_START && fall_ev && !START_REQUEST_SET)
    |=> !c_r.start_req && state_r == tms_pkg::ST_HOLD && c_r.scl_low && c_r.sda_low)
    else $error("start not completed");
  free_pins_float_a: assert property (
    state_r == tms_pkg::ST_FREE |-> !c_r.scl_low && (!c_r.sda_low || c_r.start_req))
    else $error("free bus still pulled");
  ack_release_a: assert property (
    (state_r == tms_pkg::ST_BYTE && c_r.is_tx && c_r.cnt == tms_pkg::ACK_IDX) |-> !c_r.sda_low)
    else $error("data not released for ack");
  tx_ack_capture_a: assert property (
    (state_r == tms_pkg::ST_BYTE && c_r.is_tx && c_r.cnt == tms_pkg::ACK_IDX && fall_ev && c_r.scl_seen)
    |=> ACK_BIT == $past(sda_f) && !TX_ACTIVE_FLAG)
    else $error("ack not captured");
  rx_load_ready_a: assert property (
    (state_r == tms_pkg::ST_BYTE && !c_r.is_tx && c_r.cnt == tms_pkg::LAST_DATA_IDX && fall_ev && c_r.scl_seen)
    |=> RX_BYTE_READY && !RX_ACTIVE_FLAG && SHIFT_DATA_BYTE == 8'({$past(c_r.shift), $past(sda_f)}))
    else $error("received byte not loaded");
  rx_ack_drive_a: assert property (
    (state_r == tms_pkg::ST_BYTE && !c_r.is_tx && c_r.cnt == tms_pkg::LAST_DATA_IDX && fall_ev && c_r.scl_seen)
    |=> c_r.sda_low == !$past(ACK_SETTING))
    else $error("ack setting not driven");
  hold_clock_low_a: assert property (
    state_r == tms_pkg::ST_HOLD |-> c_r.scl_low)
    else $error("paused bus clock released");
  stretch_wait_a: assert property (
    (state_r == tms_pkg::ST_BYTE && fall_ev && !c_r.scl_seen) |=> $stable(c_r.cnt))
    else $error("bit advanced during stretch");
  tx_empty_load_a: assert property (
    TX_EMPTY_EVENT |-> TX_ACTIVE_FLAG && c_r.cnt == tms_pkg::CNT_RST && $past(pop))
    else $error("transmit empty out of place");
  disable_frees_a: assert property (
    (CE && !MASTER_ENABLE) |=> state_r == tms_pkg::ST_FREE && !SERIAL_DATA_PIN_OE && !SERIAL_CLOCK_PIN_OE)
    else $error("disable did not free bus");
  stop_self_clear_a: assert property (
    (state_r == tms_pkg::ST_STOP2 && fall_ev && c_r.scl_seen && !STOP_REQUEST_SET)
    |=> !c_r.stop_req && !BUS_BUSY ##1 !BUS_BUSY)
    else $error("stop not completed");

  start_seen_c: cover property (state_r == tms_pkg::ST_START ##1 state_r == tms_pkg::ST_HOLD);
  tx_byte_c: cover property ($fell(TX_ACTIVE_FLAG));
  rx_byte_c: cover property ($rose(RX_BYTE_READY));
  rep_start_c: cover property (state_r == tms_pkg::ST_RSHI ##1 state_r == tms_pkg::ST_START);
  stop_seen_c: cover property ($fell(BUS_BUSY));
endmodule
`default_nettype wire

// [verification/tms_slave.sv]
// behavioural two-wire slave standing on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module tms_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  input wire logic stretch,
  input wire logic [7:0] rd_byte,
  output logic sda_oe = 1'b0,
  output logic scl_oe = 1'b0,
  output logic [7:0] last_rx = 8'h00,
  output logic [7:0] nbytes = 8'h00,
  output logic [1:0] acks = 2'b00
);
  int bitn = 0;
  logic [7:0] sh = 8'h00;
  logic addr_ph = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  // start or repeated start rearms the address phase
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      addr_ph = 1'b1;
      sel = 1'b0;
      rd = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) sel = 1'b0;
  end
  // sample on rising clock; master nak ends a read
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (bitn == 8 && rd && sel) begin
      acks = {acks[0], sda};
      if (sda) sel = 1'b0;
    end
    bitn = bitn + 1;
  end
  // change data only while clock is low, pull low or release
  always @(negedge scl) begin
    if (bitn == 8 && addr_ph) begin
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      addr_ph = 1'b0;
      sda_oe = sel;
    end else if (bitn == 8 && !rd && sel) begin
      last_rx = sh;
      nbytes = nbytes + 8'h01;
      sda_oe = !nak;
    end else if (bitn >= 8) begin
      sda_oe = (bitn == 9 && rd && sel) ? !rd_byte[7] : 1'b0;
      if (bitn == 9) begin
        bitn = 0;
        // slow answer: hold the clock low after each byte
        if (stretch) begin
          scl_oe = 1'b1;
          #300;
          scl_oe = 1'b0;
        end
      end
    end else sda_oe = rd && sel && !rd_byte[7-bitn];
  end
endmodule
`default_nettype wire

// [verification/tms_master_tb.sv]
// self-checking bench for the two-wire master
`timescale 1ns/1ps
`default_nettype none
module tms_master_tb;
  localparam logic [6:0] SADDR = 7'h2a;
  localparam logic [7:0] RDB = 8'hb6;
  logic clk, rst_n, men, nf, bclk, st_set, sp_set, cv, ack_set, rx_rd, nak, stretch, ce;
  logic crdy, st_r, sp_r, txq, rxq, ack_b, tx_a, rx_a, rdy, tx_ev, busy;
  logic sda_oe, scl_oe, sda_o, scl_o, s_sda_oe, s_scl_oe;
  logic [7:0] sdb, last_rx, nbytes;
  logic [1:0] acks;
  tms_pkg::tms_cmd_t cmd;
  // pull-ups: a released line reads high
  // data settles just after the clock edge, else the slave model races a false start or stop
  wire logic sda_w;
  assign #1 sda_w = ~(sda_oe | s_sda_oe);
  wire logic scl_w = ~(scl_oe | s_scl_oe);
  int fails = 0;
  int checked = 0;
  int n_ev = 0;
  int n_rxa = 0;
  int n_start = 0;
  int n_stop = 0;
  tms_master i_dut (.CLOCK(clk), .RESETN(rst_n), .CE(ce), .MASTER_ENABLE(men),
    .NOISE_FILTER_ON(nf), .BIT_CLOCK(bclk), .START_REQUEST_SET(st_set),
    .STOP_REQUEST_SET(sp_set), .CMD_VALID(cv), .CMD_READY(crdy), .CMD(cmd),
    .ACK_SETTING(ack_set), .RX_READ(rx_rd), .START_REQUEST(st_r), .STOP_REQUEST(sp_r),
    .TRANSMIT_REQUEST(txq), .RECEIVE_REQUEST(rxq), .ACK_BIT(ack_b), .TX_ACTIVE_FLAG(tx_a),
    .RX_ACTIVE_FLAG(rx_a), .RX_BYTE_READY(rdy), .SHIFT_DATA_BYTE(sdb), .TX_EMPTY_EVENT(tx_ev),
    .BUS_BUSY(busy), .SERIAL_DATA_PIN_I(sda_w), .SERIAL_DATA_PIN_O(sda_o),
    .SERIAL_DATA_PIN_OE(sda_oe), .SERIAL_CLOCK_PIN_I(scl_w), .SERIAL_CLOCK_PIN_O(scl_o),
    .SERIAL_CLOCK_PIN_OE(scl_oe));
  tms_slave #(.ADDR(SADDR)) i_slave (.scl(scl_w), .sda(sda_w), .nak(nak), .stretch(stretch),
    .rd_byte(RDB), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe), .last_rx(last_rx), .nbytes(nbytes),
    .acks(acks));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // free running, phase unrelated to clk, 125 ns is far below clk/6
  initial begin
    bclk = 1'b0;
    #7.3;
    forever #62.5 bclk = ~bclk;
  end
  always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
  always @(posedge sda_w) if (scl_w === 1'b1) n_stop++;
  always @(posedge clk) begin
    if (tx_ev === 1'b1) n_ev++;
    if (tx_ev === 1'b1) chk("tx_active", {7'h00, tx_a}, 8'h01); // busy at load
    if (rx_a === 1'b1) n_rxa++;
    chk("pin_out", {6'h00, sda_o, scl_o}, 8'h00); // pins never drive high
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return st_r === 1'b0;
      1: return sp_r === 1'b0;
      2: return txq === 1'b0 && tx_a === 1'b0;
      default: return rdy === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (!cond(k) && n < 30000) begin
      step();
      n++;
    end
    if (!cond(k)) begin
      fails++;
      test_done();
    end
  endtask
  // 0 start, 1 stop, 2 read of the received byte
  task automatic pulse(input int k);
    st_set = (k == 0);
    sp_set = (k == 1);
    rx_rd = (k == 2);
    step();
    {st_set, sp_set, rx_rd} = 3'b000;
  endtask
  task automatic push(input logic tx, input logic rx, input logic [7:0] d);
    cmd = {tx, rx, d};
    cv = 1'b1;
    step();
    cv = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, men, nf, st_set, sp_set, cv, ack_set, rx_rd, nak, stretch} = '0;
    cmd = '0;
    ce = 1'b1;
    #1;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("rst_flags", {crdy, st_r, sp_r, txq, rxq, ack_b, tx_a, rx_a}, 8'h80);
    chk("rst_pins", {4'h0, sda_oe, scl_oe, rdy, busy}, 8'h00);
    chk("rst_data", sdb, 8'h00);
    n_start = 0;
    n_stop = 0;
    repeat (4) step();
    for (int p = 0; p < 2; p++) begin
      // options change only while disabled
      nf = p[0];
      stretch = p[0];
      step();
      men = 1'b1;
      repeat (4) step();
      // fill the queue: address as a plain byte, then 31 data bytes
      for (int i = 0; i < 32; i++) begin
        chk("ready", {7'h00, crdy}, 8'h01); // room left
        cmd = {1'b1, 1'b0, (i == 0) ? {SADDR, 1'b0} : (8'h5a ^ 8'(i))};
        cv = 1'b1;
        step();
      end
      cv = 1'b0;
      chk("full", {7'h00, crdy}, 8'h00); // 32 words held
      chk("tx_pending", {7'h00, txq}, 8'h01); // queued until start
      push(1'b1, 1'b0, 8'hee);
      chk("busy_free", {7'h00, busy}, 8'h00);
      pulse(0);
      wait_for(0);
      chk("busy_start", {7'h00, busy}, 8'h01); // self-clear then busy
      wait_for(2);
      chk("rx_count", nbytes, 8'(32 * p + 31)); // refused word never sent
      chk("last_byte", last_rx, 8'h5a ^ 8'd31); // msb first, 9 clocks
      chk("ack", {7'h00, ack_b}, 8'h00); // slave acknowledged
      chk("tx_events", 8'(n_ev), 8'(34 * p + 32)); // one per loaded byte
      nak = 1'b1;
      push(1'b1, 1'b0, 8'h3c);
      step();
      wait_for(2);
      chk("nak", {7'h00, ack_b}, 8'h01); // data left high
      chk("nak_byte", last_rx, 8'h3c);
      nak = 1'b0;
      pulse(0);
      wait_for(0);
      chk("rs_busy", {7'h00, busy}, 8'h01); // bus stays busy
      // read address plus a byte in one command, then a second read
      push(1'b1, 1'b1, {SADDR, 1'b1});
      step();
      push(1'b0, 1'b1, 8'h00);
      wait_for(3);
      chk("rx1", sdb, RDB);
      chk("rx_active_end", {7'h00, rx_a}, 8'h00);
      chk("rx_pending", {7'h00, rxq}, 8'h01); // second read still queued
      ack_set = 1'b1;
      pulse(2);
      chk("ready_clr", {7'h00, rdy}, 8'h00); // cleared by the read
      wait_for(3);
      chk("rx2", sdb, RDB);
      chk("rx_req_done", {7'h00, rxq}, 8'h00);
      chk("rx_active_seen", {7'h00, n_rxa != 0}, 8'h01);
      pulse(2);
      ack_set = 1'b0;
      // past the ack clock and any stretching before stop
      repeat (150) step();
      pulse(1);
      wait_for(1);
      step();
      chk("acks", {6'h00, acks}, 8'h01); // ack then nak sent
      chk("busy_stop", {7'h00, busy}, 8'h00);
      chk("lines_free", {6'h00, sda_w, scl_w}, 8'h03);
      chk("starts", 8'(n_start), 8'(2 * p + 2)); // start and repeated start
      chk("stops", 8'(n_stop), 8'(p + 1));
      // disable only after stop cleared
      men = 1'b0;
      step();
    end
    ce = 1'b0;
    pulse(0);
    chk("ce_freeze", {7'h00, st_r}, 8'h00); // frozen, start set not taken
    ce = 1'b1;
    step();
    pulse(0);
    repeat (200) step();
    chk("dis_start", {7'h00, st_r}, 8'h01); // no bus activity while disabled
    chk("dis_pins", {6'h00, sda_oe, scl_oe}, 8'h00);
    test_done();
  end
  // hang guard: about 100000 clocks
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
